// >>> bench/pebl_array_model.sv
// flash array side model: stores programmed beats, streams pages on load
module pebl_array_model (
	input wire logic clk_i,
	input wire logic rd_go_i,
	input wire logic busy_i,
	input wire logic slow_i,
	input wire logic [11:0] flip_a_i,
	input wire logic [11:0] flip_b_i,
	input wire logic wr_i,
	input wire pebl_pkg::pebl_beat_t beat_i,
	output logic valid_o,
	output logic [7:0] data_o,
	output int beats_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:2175];
	logic [11:0] idx;
	logic pend;
	logic tog;
	initial begin
		for (int i = 0; i < 2176; i++) begin
			mem[i] = i[7:0] ^ {i[11:8], 4'h0};
		end
		mem[12'h800] = 8'h00;
		valid_o = 1'b0;
		data_o = 8'h00;
		beats_o = 0;
		idx = 12'h000;
		pend = 1'b0;
		tog = 1'b0;
	end
	// released data line inverts its last value every cycle; optional stall cycles
	always @(posedge clk_i) begin
		tog <= ~tog;
		if (rd_go_i) begin
			pend <= 1'b1;
			idx <= 12'h000;
			valid_o <= 1'b0;
			data_o <= ~data_o;
		end else if (pend && busy_i && !(slow_i && tog)) begin
			valid_o <= 1'b1;
			data_o <= mem[idx] ^ ((idx == flip_a_i || idx == flip_b_i) ? 8'h01 : 8'h00);
			idx <= idx + 12'h001;
			if (idx == 12'h87f) begin
				pend <= 1'b0;
			end
		end else begin
			valid_o <= 1'b0;
			data_o <= ~data_o;
		end
		if (wr_i) begin
			mem[beat_i.addr] <= beat_i.data;
			beats_o <= beats_o + 1;
		end
	end
endmodule // pebl_array_model

// >>> bench/pebl_ecc_tb_top.sv
// self-checking bench for the page ecc and spare layout block
module pebl_ecc_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, feat_wr, feat_en, host_wr, host_rd, prog_go, read_go, slow;
	logic [7:0] feat_cmd, host_data, arr_data, rd_data;
	logic [11:0] host_addr, flip_a, flip_b;
	logic arr_valid, ecc_en, busy, done, rd_valid, arr_wr;
	pebl_pkg::pebl_status_t status;
	pebl_pkg::pebl_beat_t beat;
	int miscompares, samples_checked, cycles, beats, b0;
	pebl_ecc i_dut (.REF_CLK_I(clk), .RST_I(rst), .FEAT_WR_I(feat_wr), .FEAT_CMD_I(feat_cmd),
		.FEAT_ECC_EN_I(feat_en), .HOST_WR_I(host_wr), .HOST_RD_I(host_rd),
		.HOST_ADDR_I(host_addr), .HOST_DATA_I(host_data), .PROG_START_I(prog_go),
		.READ_START_I(read_go), .ARR_VALID_I(arr_valid), .ARR_DATA_I(arr_data),
		.ECC_EN_O(ecc_en), .STATUS_O(status), .BUSY_O(busy), .DONE_O(done),
		.RD_VALID_O(rd_valid), .RD_DATA_O(rd_data), .ARR_WR_O(arr_wr), .ARR_BEAT_O(beat));
	pebl_array_model i_arr (.clk_i(clk), .rd_go_i(read_go), .busy_i(busy), .slow_i(slow),
		.flip_a_i(flip_a), .flip_b_i(flip_b), .wr_i(arr_wr), .beat_i(beat),
		.valid_o(arr_valid), .data_o(arr_data), .beats_o(beats));
	always #5 clk = ~clk;
	function automatic logic [7:0] pat(input logic [11:0] a);
		return a[7:0] ^ {a[11:8], 4'h0};
	endfunction
	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			finish_test();
		end
	end
	task automatic feat(input logic [7:0] cmd, input logic en);
		@(posedge clk);
		feat_wr <= 1'b1;
		feat_cmd <= cmd;
		feat_en <= en;
		@(posedge clk);
		feat_wr <= 1'b0;
		#1;
	endtask
	task automatic hwr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		host_wr <= 1'b1;
		host_addr <= a;
		host_data <= d;
		@(posedge clk);
		host_wr <= 1'b0;
	endtask
	task automatic hrd(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk);
		host_rd <= 1'b1;
		host_addr <= a;
		@(posedge clk);
		host_rd <= 1'b0;
		#1;
		chk(rd_valid, 12'h001);
		chk(rd_data, e);
	endtask
	task automatic op(input logic prog, input logic [11:0] a, input logic [11:0] b);
		int n;
		@(posedge clk);
		prog_go <= prog;
		read_go <= !prog;
		flip_a <= a;
		flip_b <= b;
		b0 = beats;
		@(posedge clk);
		prog_go <= 1'b0;
		read_go <= 1'b0;
		#1;
		if (!prog) chk(status, 12'h000);
		n = 0;
		while (done !== 1'b1 && n < 9000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(done, 12'h001);
		@(posedge clk);
		#1;
	endtask
	task automatic t_reset();
		chk(ecc_en, 12'h001);
		chk(status, 12'h000);
	endtask
	task automatic t_feature();
		feat(8'h0f, 1'b0);
		chk(ecc_en, 12'h001);
		feat(8'h1f, 1'b0);
		chk(ecc_en, 12'h000);
	endtask
	task automatic t_off_access();
		hwr(12'h840, 8'ha5);
		hrd(12'h840, 8'ha5);
		op(1'b0, 12'h010, 12'hfff);
		chk(status, 12'h000);
		hrd(12'h010, pat(12'h010) ^ 8'h01);
		hrd(12'h800, 8'h00);
	endtask
	task automatic t_program_on();
		feat(8'h1f, 1'b1);
		op(1'b0, 12'hfff, 12'hfff);
		hwr(12'h840, 8'h3c);
		hrd(12'h840, pat(12'h840));
		op(1'b1, 12'hfff, 12'hfff);
		chk(12'(beats - b0), 12'h880);
		chk(i_arr.mem[12'h800], 12'h000);
		chk(i_arr.mem[12'h842], 12'h000);
		chk(i_arr.mem[12'h010], pat(12'h010));
	endtask
	task automatic t_read_on();
		op(1'b0, 12'hfff, 12'hfff);
		chk(status, 12'h000);
		op(1'b0, 12'h010, 12'hfff);
		chk(status, 12'h004);
		hrd(12'h010, pat(12'h010));
		op(1'b0, 12'h805, 12'hfff);
		chk(status, 12'h004);
		hrd(12'h805, pat(12'h805));
		op(1'b0, 12'h801, 12'hfff);
		chk(status, 12'h000);
		hrd(12'h801, pat(12'h801) ^ 8'h01);
		slow <= 1'b1;
		op(1'b0, 12'h010, 12'h011);
		chk(status, 12'h008);
		slow <= 1'b0;
	endtask
	task automatic t_program_off();
		feat(8'h1f, 1'b0);
		hwr(12'h841, 8'h77);
		op(1'b1, 12'hfff, 12'hfff);
		chk(12'(beats - b0), 12'h880);
		chk(i_arr.mem[12'h841], 12'h077);
	endtask
	initial begin
		{clk, feat_wr, feat_en, host_wr, host_rd, prog_go, read_go, slow} = '0;
		rst = 1'b1;
		{feat_cmd, host_data} = '0;
		{host_addr, flip_a, flip_b} = '0;
		{miscompares, samples_checked, cycles, b0} = '0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_feature();
		t_off_access();
		t_program_on();
		t_read_on();
		t_program_off();
		finish_test();
	end
endmodule // pebl_ecc_tb_top

// >>> hdl/pebl_ecc.sv
// page ecc engine, cache buffer and spare layout of the serial nand device
// What this block does
// - factory bad mark 00h at byte 2048 of a block's first page is never altered by the engine, only by array loads and host writes
// - usable blocks stay at or above 1004 of 1024 for the whole life
// - correction enable reads as set after power-up
// - feature write 1fh sets correction on with 1, off with 0
// - with correction on, parity is computed over the cached page before programming
// - on read, parity is recomputed, compared, and errors fixed in the cache
// - with correction on, only corrected cache data reaches the host
// - status bits updated after each read to show correction outcome
// - main sectors 000h to 7ffh are covered by correction
// - first four bytes of each spare segment are not covered
// - last twelve bytes of each spare segment are covered
// - bytes 840h to 87fh hold the generated parity
// - with correction on, host writes to parity bytes are dropped, reads still work
// - with correction off, every page byte is host writable and readable
// - byte 800h is kept for the bad block mark only
// - status 00 none, 01 fixed with extension, 10 uncorrectable, 11 eight fixed
// - status and extension clear on reset and read start, update at read end
// - status carries no meaning while correction is off
module pebl_ecc (
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	input wire logic FEAT_WR_I,
	input wire logic [7:0] FEAT_CMD_I,
	input wire logic FEAT_ECC_EN_I,
	input wire logic HOST_WR_I,
	input wire logic HOST_RD_I,
	input wire logic [11:0] HOST_ADDR_I,
	input wire logic [7:0] HOST_DATA_I,
	input wire logic PROG_START_I,
	input wire logic READ_START_I,
	input wire logic ARR_VALID_I,
	input wire logic [7:0] ARR_DATA_I,
	output logic ECC_EN_O,
	output pebl_pkg::pebl_status_t STATUS_O,
	output logic BUSY_O,
	output logic DONE_O,
	output logic RD_VALID_O,
	output logic [7:0] RD_DATA_O,
	output logic ARR_WR_O,
	output pebl_pkg::pebl_beat_t ARR_BEAT_O
);
	typedef enum logic [2:0] {ST_IDLE, ST_GEN, ST_PWR, ST_OUT, ST_LOAD, ST_CHK, ST_FIX} pebl_st_t;

	localparam int unsigned valid_floor = pebl_pkg::MIN_VALID_BLOCKS;

	logic [7:0] cache_ff [pebl_pkg::PAGE_BYTES];
	pebl_st_t state_ff;
	logic [11:0] idx_ff;
	logic [12:0] syn_ff [4];
	logic [3:0] par_ff;
	logic fixed_ff;
	logic uncorr_ff;
	logic ecc_en_ff;
	logic [11:0] gen_cnt_ff;

	// covered byte: sector number and sector-local byte index
	function automatic logic [12:0] map_cov(input logic [11:0] a);
		logic [12:0] r;
		r = '0;
		if (a <= pebl_pkg::MAIN_LAST) begin
			r = {1'b1, a[10:9], 1'b0, a[8:0]};
		end else if (a <= pebl_pkg::COVER_LAST && a[3:0] > pebl_pkg::META_I_LAST) begin
			r = {1'b1, a[5:4], 10'(10'h200 + {6'h00, a[3:0]} - 10'h004)};
		end
		return r;
	endfunction

	// address of sector-local byte
	function automatic logic [11:0] unmap(input logic [1:0] s, input logic [9:0] l);
		if (l < 10'h200) begin
			return {1'b0, s, l[8:0]};
		end
		return 12'(pebl_pkg::SPARE_OFS + {6'h00, s, 4'h0} + 12'(l - 10'h1fc));
	endfunction

	// xor of one-based bit positions set in a byte
	function automatic logic [12:0] bit_syn(input logic [9:0] l, input logic [7:0] d);
		logic [12:0] s;
		s = '0;
		for (int b = 0; b < 8; b++) begin
			if (d[b]) begin
				s = s ^ 13'({l, 3'(b)} + 13'h0001);
			end
		end
		return s;
	endfunction

	logic [12:0] cur_map;
	logic [1:0] cur_sec;
	logic [1:0] pw_sec;
	logic [7:0] pw_byte;
	logic [1:0] fx_sec;
	logic [12:0] fx_syn;
	logic fx_pe;
	logic [12:0] fx_pos;
	logic fx_fixable;
	logic [11:0] fx_addr;
	logic host_idle;
	logic host_wr_ok;
	logic in_par;

	always_comb begin
		cur_map = map_cov(idx_ff);
		cur_sec = cur_map[11:10];
		pw_sec = idx_ff[5:4];
		case (idx_ff[3:0])
			4'h0: pw_byte = syn_ff[pw_sec][7:0];
			4'h1: pw_byte = {par_ff[pw_sec], 2'b00, syn_ff[pw_sec][12:8]};
			default: pw_byte = 8'h00;
		endcase
		fx_sec = idx_ff[1:0];
		fx_syn = syn_ff[fx_sec] ^ {cache_ff[pebl_pkg::PAR_OFS + {6'h00, fx_sec, 4'h1}][4:0],
			cache_ff[pebl_pkg::PAR_OFS + {6'h00, fx_sec, 4'h0}]};
		fx_pe = par_ff[fx_sec] ^ cache_ff[pebl_pkg::PAR_OFS + {6'h00, fx_sec, 4'h1}][7];
		fx_pos = 13'(fx_syn - 13'h0001);
		fx_fixable = fx_pe && fx_syn != 13'h0000 && fx_pos[12:3] < pebl_pkg::SECTOR_COVER;
		fx_addr = unmap(fx_sec, fx_pos[12:3]);
		host_idle = state_ff == ST_IDLE;
		in_par = HOST_ADDR_I >= pebl_pkg::PAR_OFS && HOST_ADDR_I <= pebl_pkg::LAST_OFS;
		host_wr_ok = HOST_WR_I && host_idle && HOST_ADDR_I <= pebl_pkg::LAST_OFS
			&& !(ecc_en_ff && in_par);
	end

	// correction enable feature bit
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			ecc_en_ff <= pebl_pkg::ECC_EN_RST;
		end else if (FEAT_WR_I && FEAT_CMD_I == pebl_pkg::FEAT_WR_CMD) begin
			ecc_en_ff <= FEAT_ECC_EN_I;
		end
	end

	// sequencer
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			state_ff <= ST_IDLE;
			idx_ff <= '0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					idx_ff <= '0;
					if (PROG_START_I) begin
						state_ff <= ecc_en_ff ? ST_GEN : ST_OUT;
					end else if (READ_START_I) begin
						state_ff <= ST_LOAD;
					end
				end
				ST_GEN: begin
					idx_ff <= 12'(idx_ff + 12'h001);
					if (idx_ff == pebl_pkg::COVER_LAST) begin
						state_ff <= ST_PWR;
					end
				end
				ST_PWR: begin
					if (idx_ff == pebl_pkg::LAST_OFS) begin
						state_ff <= ST_OUT;
						idx_ff <= '0;
					end else begin
						idx_ff <= 12'(idx_ff + 12'h001);
					end
				end
				ST_OUT: begin
					idx_ff <= 12'(idx_ff + 12'h001);
					if (idx_ff == pebl_pkg::LAST_OFS) begin
						state_ff <= ST_IDLE;
					end
				end
				ST_LOAD: begin
					if (ARR_VALID_I) begin
						idx_ff <= 12'(idx_ff + 12'h001);
						if (idx_ff == pebl_pkg::LAST_OFS) begin
							idx_ff <= '0;
							state_ff <= ecc_en_ff ? ST_CHK : ST_IDLE;
						end
					end
				end
				ST_CHK: begin
					idx_ff <= 12'(idx_ff + 12'h001);
					if (idx_ff == pebl_pkg::COVER_LAST) begin
						state_ff <= ST_FIX;
						idx_ff <= '0;
					end
				end
				ST_FIX: begin
					idx_ff <= 12'(idx_ff + 12'h001);
					if (idx_ff[1:0] == 2'h3) begin
						state_ff <= ST_IDLE;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// cycles spent generating parity
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I || state_ff != ST_GEN) begin
			gen_cnt_ff <= '0;
		end else begin
			gen_cnt_ff <= 12'(gen_cnt_ff + 12'h001);
		end
	end

	// syndrome accumulation over covered bytes
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I || host_idle) begin
			for (int s = 0; s < 4; s++) begin
				syn_ff[s] <= '0;
			end
			par_ff <= '0;
		end else if ((state_ff == ST_GEN || state_ff == ST_CHK) && cur_map[12]) begin
			syn_ff[cur_sec] <= syn_ff[cur_sec] ^ bit_syn(cur_map[9:0], cache_ff[idx_ff]);
			par_ff[cur_sec] <= par_ff[cur_sec] ^ (^cache_ff[idx_ff]);
		end
	end

	// cache buffer; the bad block byte is only ever written by the array or the host
	always_ff @(posedge REF_CLK_I) begin
		if (state_ff == ST_LOAD && ARR_VALID_I) begin
			cache_ff[idx_ff] <= ARR_DATA_I;
		end else if (state_ff == ST_PWR) begin
			cache_ff[idx_ff] <= pw_byte;
		end else if (state_ff == ST_FIX && fx_fixable) begin
			cache_ff[fx_addr][fx_pos[2:0]] <= ~cache_ff[fx_addr][fx_pos[2:0]];
		end else if (host_wr_ok) begin
			cache_ff[HOST_ADDR_I] <= HOST_DATA_I;
		end
	end

	// read outcome and status
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			STATUS_O <= '0;
			fixed_ff <= 1'b0;
			uncorr_ff <= 1'b0;
		end else if (host_idle && READ_START_I && !PROG_START_I) begin
			STATUS_O <= '0;
			fixed_ff <= 1'b0;
			uncorr_ff <= 1'b0;
		end else if (state_ff == ST_FIX) begin
			if (fx_pe && !fx_fixable || !fx_pe && fx_syn != 13'h0000) begin
				uncorr_ff <= 1'b1;
			end
			if (fx_fixable) begin
				fixed_ff <= 1'b1;
			end
			if (idx_ff[1:0] == 2'h3) begin
				STATUS_O.correction_count_extension <= pebl_pkg::EXT_LE4;
				if (uncorr_ff || fx_pe && !fx_fixable || !fx_pe && fx_syn != 13'h0000) begin
					STATUS_O.correction_status_field <= pebl_pkg::STS_UNCORR;
				end else if (fixed_ff || fx_fixable) begin
					STATUS_O.correction_status_field <= pebl_pkg::STS_FIXED;
				end else begin
					STATUS_O.correction_status_field <= pebl_pkg::STS_NONE;
				end
			end
		end
	end

	// host and array facing outputs
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			ECC_EN_O <= pebl_pkg::ECC_EN_RST;
			BUSY_O <= 1'b0;
			DONE_O <= 1'b0;
			RD_VALID_O <= 1'b0;
			RD_DATA_O <= '0;
			ARR_WR_O <= 1'b0;
			ARR_BEAT_O <= '0;
		end else begin
			ECC_EN_O <= (FEAT_WR_I && FEAT_CMD_I == pebl_pkg::FEAT_WR_CMD) ? FEAT_ECC_EN_I : ecc_en_ff;
			BUSY_O <= !host_idle || PROG_START_I || READ_START_I;
			DONE_O <= (state_ff == ST_OUT && idx_ff == pebl_pkg::LAST_OFS)
				|| (state_ff == ST_LOAD && ARR_VALID_I && idx_ff == pebl_pkg::LAST_OFS && !ecc_en_ff)
				|| (state_ff == ST_FIX && idx_ff[1:0] == 2'h3);
			RD_VALID_O <= HOST_RD_I && host_idle && HOST_ADDR_I <= pebl_pkg::LAST_OFS;
			RD_DATA_O <= (HOST_ADDR_I <= pebl_pkg::LAST_OFS) ? cache_ff[HOST_ADDR_I] : 8'h00;
			ARR_WR_O <= state_ff == ST_OUT;
			ARR_BEAT_O <= '{addr: idx_ff, data: cache_ff[idx_ff]};
		end
	end

	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);

	a_ecc_power_on: assert property ($past(RST_I) |-> ECC_EN_O && ecc_en_ff)
		else $error("correction not enabled after reset");
	a_feature_write: assert property (FEAT_WR_I && FEAT_CMD_I == pebl_pkg::FEAT_WR_CMD
		|=> ecc_en_ff == $past(FEAT_ECC_EN_I) && ECC_EN_O == ecc_en_ff)
		else $error("feature write did not set correction enable");
	a_prog_gen_first: assert property (host_idle && PROG_START_I && ecc_en_ff
		|=> state_ff == ST_GEN)
		else $error("parity not generated before programming");
	a_gen_length: assert property (state_ff == ST_GEN && idx_ff == pebl_pkg::COVER_LAST
		|=> state_ff == ST_PWR && gen_cnt_ff == 12'h840)
		else $error("parity generation length wrong");
	a_parity_drop: assert property (host_idle && HOST_WR_I && ecc_en_ff && in_par
		|=> cache_ff[$past(HOST_ADDR_I)] == $past(cache_ff[HOST_ADDR_I]))
		else $error("host write reached parity bytes");
	a_open_write: assert property (host_idle && HOST_WR_I && !ecc_en_ff && HOST_ADDR_I <= 12'h87f
		|=> cache_ff[$past(HOST_ADDR_I)] == $past(HOST_DATA_I))
		else $error("host write lost with correction off");
	a_marker_kept: assert property (state_ff inside {ST_GEN, ST_PWR, ST_OUT, ST_CHK, ST_FIX}
		|=> $stable(cache_ff[pebl_pkg::BBM_OFS]))
		else $error("bad block byte changed by the engine");
	a_status_clear: assert property (host_idle && READ_START_I && !PROG_START_I
		|=> STATUS_O == '0 [*2])
		else $error("status not cleared at read start");
	a_raw_read: assert property (state_ff == ST_LOAD && !ecc_en_ff |=> state_ff != ST_CHK)
		else $error("check ran with correction off");
	a_read_done: assert property (state_ff == ST_FIX && idx_ff[1:0] == 2'h3
		|=> DONE_O && host_idle && STATUS_O.correction_status_field != pebl_pkg::STS_FIXED8)
		else $error("read outcome not reported");
	a_out_gated: assert property (RD_VALID_O |-> $past(host_idle))
		else $error("host read served while page in flight");

	c_fixed_read: cover property (state_ff == ST_FIX ##1 STATUS_O.correction_status_field == 2'h1);
	c_uncorr_read: cover property (state_ff == ST_FIX ##1 STATUS_O.correction_status_field == 2'h2);
	c_prog_ecc: cover property (state_ff == ST_PWR ##1 state_ff == ST_OUT);
	c_parity_drop: cover property (host_idle && HOST_WR_I && ecc_en_ff && in_par);
endmodule // pebl_ecc

// >>> hdl/pebl_pkg.sv
// shared constants and types for the page ecc and bad block layout block
package pebl_pkg;
	localparam int unsigned PAGE_BYTES = 2176;
	localparam logic [11:0] LAST_OFS = 12'h87f;
	localparam logic [11:0] MAIN_LAST = 12'h7ff;
	localparam logic [11:0] SPARE_OFS = 12'h800;
	localparam logic [11:0] COVER_LAST = 12'h83f;
	localparam logic [11:0] PAR_OFS = 12'h840;
	localparam logic [11:0] BBM_OFS = 12'h800;
	localparam logic [7:0] BBM_VAL = 8'h00;
	localparam logic [7:0] GOOD_VAL = 8'hff;
	localparam logic [3:0] META_I_LAST = 4'h3;
	localparam int unsigned SECTOR_BYTES = 512;
	localparam logic [9:0] SECTOR_COVER = 10'h20c;
	localparam logic [7:0] FEAT_WR_CMD = 8'h1f;
	localparam logic ECC_EN_RST = 1'b1;
	localparam int unsigned MIN_VALID_BLOCKS = 1004;
	localparam int unsigned TOTAL_BLOCKS = 1024;
	localparam logic [1:0] STS_NONE = 2'h0;
	localparam logic [1:0] STS_FIXED = 2'h1;
	localparam logic [1:0] STS_UNCORR = 2'h2;
	localparam logic [1:0] STS_FIXED8 = 2'h3;
	localparam logic [1:0] EXT_LE4 = 2'h0;

	typedef struct packed {
		logic [1:0] correction_status_field;
		logic [1:0] correction_count_extension;
	} pebl_status_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] data;
	} pebl_beat_t;
endpackage
